// >>> rtl/pxq_pkg.sv
// Package: register map, field positions and frame constants
package pxq_pkg;
  // Register indices on the management bus
  localparam logic [4:0] REG_EXT_CTRL  = 5'h10;
  localparam logic [4:0] REG_QSTAT     = 5'h11;
  // Extended control field positions
  localparam int         EC_OVR_EN     = 15;
  localparam int         EC_ADDR_LO    = 6;
  localparam int         EC_SCR_TEST   = 5;
  localparam int         EC_NRZI       = 3;
  localparam int         EC_INV_CODE   = 2;
  localparam int         EC_SCR_DIS    = 0;
  // Extended control values after reset
  localparam logic       RST_OVR_EN    = 1'h0;
  localparam logic       RST_SCR_TEST  = 1'h0;
  localparam logic       RST_NRZI      = 1'h1;
  localparam logic       RST_INV_CODE  = 1'h0;
  localparam logic       RST_SCR_DIS   = 1'h0;
  // Detailed status field positions
  localparam int         QS_RATE       = 15;
  localparam int         QS_DUPLEX     = 14;
  localparam int         QS_AN_MON_LO  = 11;
  localparam int         QS_AN_DONE    = 4;
  localparam int         QS_SIG_DET    = 3;
  localparam int         QS_LINK       = 0;
  // Latching-high event bits: 10,9,8,7,6,5 then 2,1
  localparam int         QS_EVT_HI_LO  = 5;
  localparam int         QS_EVT_LO_LO  = 1;
  // Status values after reset
  localparam logic [7:0] RST_EVT       = 8'h00;
  localparam logic [2:0] RST_AN_MON    = 3'h0;
  localparam logic       RST_LINK      = 1'h0;
  // Management frame constants
  localparam logic [5:0] PRE_ONES      = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [3:0] HDR_LAST      = 4'hB;
  localparam logic [3:0] DATA_LAST     = 4'hF;
  localparam logic [1:0] STRAP_WAIT    = 2'h3;
  // Frame receiver states
  typedef enum logic [2:0] {
    ST_PRE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } pxq_state_e;
endpackage

// >>> rtl/pxq_phy_mgmt.sv
// Extended control and quick-poll status registers behind the management port
`timescale 1ns/1ps
`default_nettype none
module pxq_phy_mgmt (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  input  wire logic       I_SOFT_RST,
  input  wire logic       I_MDC,
  input  wire logic       I_MDIO,
  output logic            O_MDIO,
  output logic            O_MDIO_OE,
  input  wire logic [4:0] I_ADDR_STRAP,
  input  wire logic       I_SPEED_PIN,
  input  wire logic       I_HW_MODE,
  input  wire logic       I_SPEED_CTRL,
  input  wire logic       I_DUPLEX,
  input  wire logic       I_AN_EN,
  input  wire logic       I_AN_RESTART,
  input  wire logic [2:0] I_AN_STATE,
  input  wire logic       I_AN_DONE,
  input  wire logic       I_SIG_DETECT,
  input  wire logic       I_LINK_OK,
  input  wire logic [7:0] I_STAT_EVT,
  input  wire logic       I_TX_BIT,
  input  wire logic       I_TX_BIT_EN,
  input  wire logic [3:0] I_TX_NIBBLE,
  input  wire logic       I_TX_ER,
  input  wire logic [4:0] I_TX_STD_CODE,
  output logic            O_TX_SER,
  output logic [4:0]      O_TX_CODE,
  output logic            O_SCR_EN,
  output logic            O_DESCR_UNLOCK,
  output logic            O_OVR_ARMED,
  output logic [4:0]      O_PHY_ADDR,
  output logic            O_SPEED_100
);
  import pxq_pkg::*;

  typedef struct packed {
    logic       mdc_s1;
    logic       mdc_s2;
    logic       mdc_d;
    logic       mdio_s1;
    logic       mdio_s2;
    logic       spd_s1;
    logic       spd_s2;
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic [1:0] strap_cnt;
    logic       addr_ok;
    logic [4:0] phy_addr;
    pxq_state_e state;
    logic [5:0] pre_cnt;
    logic [3:0] cnt;
    logic [11:0] hdr;
    logic       rd;
    logic [15:0] sh;
    logic       mdio_out;
    logic       mdio_oe;
    logic       ovr_en;
    logic       scr_test;
    logic       nrzi;
    logic       inv_code;
    logic       scr_dis;
    logic [7:0] evt;
    logic [2:0] an_mon;
    logic       link;
    logic       tx_ser;
    logic [4:0] tx_code;
  } pxq_regs_s;

  pxq_regs_s r;
  pxq_regs_s next_r;

  // Test translation of a transmit nibble
  function automatic logic [4:0] test_code(input logic [3:0] nib);
    logic [4:0] c;
    c = {1'h0, nib};
    case (nib)
      4'h8: c = 5'h00;
      4'h9: c = 5'h0D;
      4'hA: c = 5'h0C;
      4'hB: c = 5'h11;
      4'hC: c = 5'h10;
      4'hD: c = 5'h19;
      4'hE: c = 5'h18;
      4'hF: c = 5'h1F;
      default: c = {1'h0, nib};
    endcase
    return c;
  endfunction

  logic        speed100;
  logic        mdc_rise;
  logic        bit_in;
  logic [15:0] ext_rd;
  logic [15:0] qs_rd;
  logic [1:0]  hdr_op;
  logic [4:0]  hdr_pa;
  logic [4:0]  hdr_ra;

  // Live data rate and readback words
  always_comb begin
    speed100 = I_HW_MODE ? r.spd_s2 : I_SPEED_CTRL;
    mdc_rise = r.mdc_s2 & ~r.mdc_d;
    bit_in   = r.mdio_s2;
    // Header fields as they stand at the last header bit
    hdr_op   = r.hdr[10:9];
    hdr_pa   = r.hdr[8:4];
    hdr_ra   = {r.hdr[3:0], bit_in};
    ext_rd   = 16'h0000;
    ext_rd[EC_OVR_EN]                = r.ovr_en;
    ext_rd[EC_ADDR_LO +: 5]          = r.phy_addr;
    ext_rd[EC_SCR_TEST]              = r.scr_test;
    ext_rd[EC_NRZI]                  = r.nrzi;
    ext_rd[EC_INV_CODE]              = r.inv_code;
    ext_rd[EC_SCR_DIS]               = r.scr_dis;
    qs_rd    = 16'h0000;
    qs_rd[QS_RATE]                   = speed100;
    qs_rd[QS_DUPLEX]                 = I_DUPLEX;
    qs_rd[QS_AN_MON_LO +: 3]         = r.an_mon;
    qs_rd[QS_EVT_HI_LO +: 6]         = r.evt[7:2];
    qs_rd[QS_AN_DONE]                = I_AN_DONE;
    qs_rd[QS_SIG_DET]                = I_SIG_DETECT;
    qs_rd[QS_EVT_LO_LO +: 2]         = r.evt[1:0];
    qs_rd[QS_LINK]                   = r.link;
  end

  // Next-state logic of the whole block
  always_comb begin
    next_r          = r;
    next_r.mdc_s1   = I_MDC;
    next_r.mdc_s2   = r.mdc_s1;
    next_r.mdc_d    = r.mdc_s2;
    next_r.mdio_s1  = I_MDIO;
    next_r.mdio_s2  = r.mdio_s1;
    next_r.spd_s1   = I_SPEED_PIN;
    next_r.spd_s2   = r.spd_s1;
    next_r.strap_s1 = I_ADDR_STRAP;
    next_r.strap_s2 = r.strap_s1;

    // Address straps caught once the synchroniser has settled
    if (!r.addr_ok) begin
      if (r.strap_cnt == STRAP_WAIT) begin
        next_r.phy_addr = r.strap_s2;
        next_r.addr_ok  = 1'h1;
      end else begin
        next_r.strap_cnt = r.strap_cnt + 2'h1;
      end
    end

    // Latching status: events set, link drops latch low
    next_r.evt  = r.evt | I_STAT_EVT;
    next_r.link = r.link & I_LINK_OK;
    if (!I_AN_EN || I_AN_RESTART) begin
      next_r.an_mon = RST_AN_MON;
    end else if (I_AN_STATE > r.an_mon) begin
      next_r.an_mon = I_AN_STATE;
    end

    // Management frame receiver on rising MDC
    if (mdc_rise) begin
      case (r.state)
        ST_PRE: begin
          if (bit_in) begin
            if (r.pre_cnt != PRE_ONES) begin
              next_r.pre_cnt = r.pre_cnt + 6'h01;
            end
          end else if (r.pre_cnt == PRE_ONES && r.addr_ok) begin
            next_r.state = ST_START;
          end else begin
            next_r.pre_cnt = 6'h00;
          end
        end
        ST_START: begin
          next_r.pre_cnt = 6'h00;
          next_r.cnt     = 4'h0;
          next_r.state   = bit_in ? ST_HDR : ST_PRE;
        end
        ST_HDR: begin
          next_r.hdr = {r.hdr[10:0], bit_in};
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == HDR_LAST) begin
            next_r.cnt   = 4'h0;
            next_r.state = ST_PRE;
            // Only frames for this address go on past the header
            if (hdr_pa == r.phy_addr) begin
              if (hdr_op == OP_READ) begin
                if (hdr_ra == REG_EXT_CTRL) begin
                  next_r.state = ST_TA;
                  next_r.rd    = 1'h1;
                  next_r.sh    = ext_rd;
                end else if (hdr_ra == REG_QSTAT) begin
                  next_r.state = ST_TA;
                  next_r.rd    = 1'h1;
                  next_r.sh    = qs_rd;
                  // Read returns history, then latches the current condition
                  next_r.evt    = I_STAT_EVT;
                  next_r.link   = I_LINK_OK;
                  next_r.an_mon = I_AN_EN && !I_AN_RESTART ? I_AN_STATE : RST_AN_MON;
                end
              end else if (hdr_op == OP_WRITE) begin
                next_r.state = ST_TA;
                next_r.rd    = 1'h0;
                next_r.sh    = {11'h000, hdr_ra};
              end
            end
          end
        end
        ST_TA: begin
          // Turnaround: a read drives zero on its second bit
          next_r.cnt = r.cnt + 4'h1;
          if (r.rd && r.cnt == 4'h0) begin
            next_r.mdio_oe  = 1'h1;
            next_r.mdio_out = 1'h0;
          end
          if (r.cnt == 4'h1) begin
            next_r.cnt   = 4'h0;
            next_r.state = ST_DATA;
            if (r.rd) begin
              next_r.mdio_out = r.sh[15];
              next_r.sh       = {r.sh[14:0], 1'h0};
            end else begin
              next_r.hdr = {7'h00, r.sh[4:0]};
            end
          end
        end
        ST_DATA: begin
          // Sixteen data bits, most significant first
          next_r.cnt = r.cnt + 4'h1;
          if (r.rd) begin
            next_r.mdio_out = r.sh[15];
            next_r.sh       = {r.sh[14:0], 1'h0};
          end else begin
            next_r.sh = {r.sh[14:0], bit_in};
          end
          if (r.cnt == DATA_LAST) begin
            next_r.state   = ST_PRE;
            next_r.mdio_oe = 1'h0;
            next_r.mdio_out = 1'h0;
            if (!r.rd) begin
              // Any write to this device consumes the override arming
              next_r.ovr_en = 1'h0;
              if (r.hdr[4:0] == REG_EXT_CTRL) begin
                next_r.ovr_en   = r.sh[EC_OVR_EN - 1];
                next_r.scr_test = r.sh[EC_SCR_TEST - 1];
                next_r.nrzi     = r.sh[EC_NRZI - 1];
                next_r.inv_code = r.sh[EC_INV_CODE - 1];
                next_r.scr_dis  = bit_in;
              end
              // Writes to the status register only clear the override arming
            end
          end
        end
        default: next_r.state = ST_PRE;
      endcase
    end

    // Serial encoder: NRZI toggles on one at 100 Mb/s
    if (I_TX_BIT_EN) begin
      if (speed100 && r.nrzi) begin
        next_r.tx_ser = r.tx_ser ^ I_TX_BIT;
      end else begin
        next_r.tx_ser = I_TX_BIT;
      end
    end

    // Symbol select: test table only under inv_code bit and TX error
    next_r.tx_code = (r.inv_code && I_TX_ER) ? test_code(I_TX_NIBBLE)
                                             : I_TX_STD_CODE;

    // Software reset restores controls and status, keeps the address
    if (I_SOFT_RST) begin
      next_r.ovr_en   = RST_OVR_EN;
      next_r.scr_test = RST_SCR_TEST;
      next_r.nrzi     = RST_NRZI;
      next_r.inv_code = RST_INV_CODE;
      next_r.scr_dis  = RST_SCR_DIS;
      next_r.evt      = RST_EVT;
      next_r.an_mon   = RST_AN_MON;
      next_r.link     = RST_LINK;
      next_r.state    = ST_PRE;
      next_r.mdio_oe  = 1'h0;
      next_r.mdio_out = 1'h0;
    end
  end

  // State register with hardware reset
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      r          <= '0;
      r.state    <= ST_PRE;
      r.nrzi     <= RST_NRZI;
      r.ovr_en   <= RST_OVR_EN;
      r.evt      <= RST_EVT;
      r.an_mon   <= RST_AN_MON;
      r.link     <= RST_LINK;
    end else begin
      r <= next_r;
    end
  end

  // Outputs toward datapath and pins
  always_comb begin
    O_MDIO         = r.mdio_out;
    O_MDIO_OE      = r.mdio_oe;
    O_TX_SER       = r.tx_ser;
    O_TX_CODE      = r.tx_code;
    O_SCR_EN       = ~(speed100 & r.scr_dis) & speed100;
    O_DESCR_UNLOCK = r.scr_test & speed100;
    O_OVR_ARMED    = r.ovr_en;
    O_PHY_ADDR     = r.phy_addr;
    O_SPEED_100    = speed100;
  end
endmodule
`default_nettype wire

// >>> verification/pxq_mgmt_assertions.sv
// Concurrent checks on the ports of the management register block
`timescale 1ns/1ps
`default_nettype none
module pxq_mgmt_assertions (
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST,
  input  wire logic       I_SOFT_RST,
  input  wire logic       I_MDC,
  input  wire logic       I_SPEED_PIN,
  input  wire logic       I_HW_MODE,
  input  wire logic       I_SPEED_CTRL,
  input  wire logic       I_TX_BIT_EN,
  input  wire logic       I_TX_ER,
  input  wire logic [4:0] I_TX_STD_CODE,
  input  wire logic       O_TX_SER,
  input  wire logic [4:0] O_TX_CODE,
  input  wire logic       O_SCR_EN,
  input  wire logic       O_DESCR_UNLOCK,
  input  wire logic       O_OVR_ARMED,
  input  wire logic [4:0] O_PHY_ADDR,
  input  wire logic       O_SPEED_100
);
  logic [3:0] rel_cnt;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  // Edges since reset release, saturating; the address may only load early
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rel_cnt <= 4'h0;
    end else if (rel_cnt != 4'hF) begin
      rel_cnt <= rel_cnt + 4'h1;
    end
  end
  // Pin held high long enough to cross the synchroniser
  sequence s_pin_high;
    (I_HW_MODE && I_SPEED_PIN)[*5];
  endsequence
  // Serial strobe quiet for three edges
  sequence s_ser_idle;
    (!I_TX_BIT_EN && !I_SOFT_RST)[*3];
  endsequence
  property p_addr_latch;
    $changed(O_PHY_ADDR) |-> rel_cnt < 4'h8;
  endproperty
  property p_addr_soft;
    I_SOFT_RST |=> $stable(O_PHY_ADDR);
  endproperty
  property p_unlock;
    O_DESCR_UNLOCK |-> O_SPEED_100;
  endproperty
  property p_scr_slow;
    !O_SPEED_100 |-> !O_SCR_EN;
  endproperty
  property p_rate_sw;
    !I_HW_MODE |-> O_SPEED_100 == I_SPEED_CTRL;
  endproperty
  property p_rate_hw;
    s_pin_high |-> O_SPEED_100;
  endproperty
  property p_code_std;
    !I_TX_ER && !I_SOFT_RST |=> O_TX_CODE == $past(I_TX_STD_CODE);
  endproperty
  property p_ovr_mdc;
    $changed(O_OVR_ARMED) && !$past(I_SOFT_RST) |-> I_MDC;
  endproperty
  property p_ser_hold;
    s_ser_idle |=> $stable(O_TX_SER);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address moved after reset");
  a_addr_soft: assert property (p_addr_soft) else $error("soft reset moved address");
  a_unlock: assert property (p_unlock) else $error("unlock outside 100");
  a_scr_slow: assert property (p_scr_slow) else $error("scrambler on at 10");
  a_rate_sw: assert property (p_rate_sw) else $error("rate not control bit");
  a_rate_hw: assert property (p_rate_hw) else $error("rate not pin");
  a_code_std: assert property (p_code_std) else $error("standard code lost");
  a_ovr_mdc: assert property (p_ovr_mdc) else $error("override moved off a write");
  a_ser_hold: assert property (p_ser_hold) else $error("serial out moved");
endmodule
bind pxq_phy_mgmt pxq_mgmt_assertions i_pxq_mgmt_assertions (
  .I_CLK_SYS, .I_RST, .I_SOFT_RST, .I_MDC, .I_SPEED_PIN, .I_HW_MODE, .I_SPEED_CTRL,
  .I_TX_BIT_EN, .I_TX_ER, .I_TX_STD_CODE, .O_TX_SER, .O_TX_CODE, .O_SCR_EN,
  .O_DESCR_UNLOCK, .O_OVR_ARMED, .O_PHY_ADDR, .O_SPEED_100
);
`default_nettype wire

// >>> verification/pxq_sta_model.sv
// Station manager model: management frames, clock stopped between frames
`timescale 1ns/1ps
`default_nettype none
module pxq_sta_model import pxq_pkg::*; (
  input  wire logic i_mdio,
  output logic      o_mdc,
  output logic      o_mdio,
  output logic      o_mdio_oe
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // Driven bit: set while the clock is low, held across the rise
  task automatic send(input logic b);
    o_mdio_oe = 1'b1;
    o_mdio = b;
    #80 o_mdc = 1'b1;
    #80 o_mdc = 1'b0;
  endtask
  // Released bit: sampled just before the rise, while the device bit stands
  task automatic take(output logic b);
    o_mdio_oe = 1'b0;
    #80 b = i_mdio;
    o_mdc = 1'b1;
    #80 o_mdc = 1'b0;
  endtask
  // Whole frame: preamble, start, opcode, addresses, turnaround, data
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [13:0] hdr;
    logic        b;
    hdr = {2'b01, rd ? OP_READ : OP_WRITE, pa, ra};
    q = 16'h0000;
    for (int i = 0; i < 32; i++) send(1'b1);
    for (int i = 13; i >= 0; i--) send(hdr[i]);
    if (rd) begin
      take(b);
      take(b);
      for (int i = 15; i >= 0; i--) take(q[i]);
    end else begin
      send(1'b1);
      send(1'b0);
      for (int i = 15; i >= 0; i--) send(wd[i]);
    end
    o_mdio_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Bench: management frames plus pin stimulus against the register block
`timescale 1ns/1ps
`default_nettype none
module tb_top import pxq_pkg::*;;
  localparam logic [4:0] ADR = 5'h0B;
  localparam logic [4:0] INV_TBL [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
  logic       clk, rst, soft_rst, mdc, sta_d, sta_oe, dut_d, dut_oe, mdio_w, ser0;
  logic       hw_mode, spd_pin, spd_ctrl, an_en, an_rst, link_ok, tx_bit, tx_en, tx_er;
  logic       tx_ser, scr_en, unlock, ovr, spd100, dpx, an_done, sig_det;
  logic [4:0] strap, tx_std, tx_code, phy_addr;
  logic [2:0] an_state;
  logic [7:0] evt;
  logic [3:0] nib;
  logic [15:0] q;
  int         mismatches, n_tests, cycles;
  // Line has a pull-up: high whenever nobody drives it
  assign mdio_w = dut_oe ? dut_d : (sta_oe ? sta_d : 1'b1);
  pxq_phy_mgmt i_pxq_phy_mgmt (.I_CLK_SYS(clk), .I_RST(rst), .I_SOFT_RST(soft_rst),
    .I_MDC(mdc), .I_MDIO(mdio_w), .O_MDIO(dut_d), .O_MDIO_OE(dut_oe), .I_ADDR_STRAP(strap),
    .I_SPEED_PIN(spd_pin), .I_HW_MODE(hw_mode), .I_SPEED_CTRL(spd_ctrl), .I_DUPLEX(dpx),
    .I_AN_EN(an_en), .I_AN_RESTART(an_rst), .I_AN_STATE(an_state), .I_AN_DONE(an_done),
    .I_SIG_DETECT(sig_det), .I_LINK_OK(link_ok), .I_STAT_EVT(evt), .I_TX_BIT(tx_bit),
    .I_TX_BIT_EN(tx_en), .I_TX_NIBBLE(nib), .I_TX_ER(tx_er), .I_TX_STD_CODE(tx_std),
    .O_TX_SER(tx_ser), .O_TX_CODE(tx_code), .O_SCR_EN(scr_en), .O_DESCR_UNLOCK(unlock),
    .O_OVR_ARMED(ovr), .O_PHY_ADDR(phy_addr), .O_SPEED_100(spd100));
  pxq_sta_model i_pxq_sta_model (.i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(sta_d),
    .o_mdio_oe(sta_oe));
  // Verdict and end of run
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_pxq_sta_model.frame(1'b0, ADR, ra, d, q);
    tick(2);
  endtask
  task automatic rdc(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
    i_pxq_sta_model.frame(1'b1, pa, ra, 16'h0000, q);
    tick(2);
    check(q, exp);
  endtask
  task automatic pulse_bit(input logic b);
    tx_bit = b;
    tx_en = 1'b1;
    tick(1);
    tx_en = 1'b0;
    tick(1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {rst, soft_rst, hw_mode, spd_pin, spd_ctrl, an_en, an_rst} = 7'b1011110;
    {link_ok, tx_bit, tx_en, tx_er} = 4'b1000;
    {dpx, an_done, sig_det} = 3'b101;
    strap = ADR;
    tx_std = 5'h15;
    an_state = 3'h0;
    evt = 8'h00;
    nib = 4'h0;
    {mismatches, n_tests, cycles} = '0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    tick(20);
    check(phy_addr, ADR);
    strap = 5'h14;
    rdc(ADR, REG_EXT_CTRL, 16'h02C8);
    // Monitor peaks at 3 then falls back; events pulse once; link drops once
    an_state = 3'h3;
    tick(2);
    an_state = 3'h1;
    evt = 8'hFF;
    link_ok = 1'b0;
    tick(1);
    evt = 8'h00;
    link_ok = 1'b1;
    tick(2);
    rdc(ADR, REG_QSTAT, 16'hDFEE);
    rdc(ADR, REG_QSTAT, 16'hC809);
    wr(REG_EXT_CTRL, 16'h802D);
    check(ovr, 1'b1);
    check(unlock, 1'b1);
    check(scr_en, 1'b0);
    rdc(ADR, REG_EXT_CTRL, 16'h82ED);
    // Every nibble through the test translation
    tx_er = 1'b1;
    for (int i = 0; i < 16; i++) begin
      nib = i[3:0];
      tick(1);
      check(tx_code, INV_TBL[i]);
    end
    tx_er = 1'b0;
    tick(1);
    check(tx_code, 5'h15);
    ser0 = tx_ser;
    pulse_bit(1'b1);
    check(tx_ser, !ser0);
    wr(REG_QSTAT, 16'hFFFF);
    check(ovr, 1'b0);
    spd_pin = 1'b0;
    tick(8);
    check(scr_en, 1'b0);
    check(unlock, 1'b0);
    rdc(ADR, REG_QSTAT, 16'h4809);
    rdc(5'h1F, REG_EXT_CTRL, 16'hFFFF);
    hw_mode = 1'b0;
    tick(1);
    check(spd100, 1'b1);
    wr(REG_EXT_CTRL, 16'h0000);
    check(scr_en, 1'b1);
    tx_er = 1'b1;
    tick(1);
    check(tx_code, 5'h15);
    pulse_bit(1'b1);
    check(tx_ser, 1'b1);
    pulse_bit(1'b0);
    check(tx_ser, 1'b0);
    an_en = 1'b0;
    an_state = 3'h5;
    {dpx, an_done, sig_det} = 3'b010;
    tick(4);
    rdc(ADR, REG_QSTAT, 16'h8011);
    // Restart drops a peak of 6; the monitor then climbs to 2 again
    an_en = 1'b1;
    an_state = 3'h6;
    tick(2);
    an_rst = 1'b1;
    an_state = 3'h2;
    tick(2);
    an_rst = 1'b0;
    tick(2);
    rdc(ADR, REG_QSTAT, 16'h9011);
    soft_rst = 1'b1;
    tick(2);
    soft_rst = 1'b0;
    tick(4);
    check(phy_addr, ADR);
    rdc(ADR, REG_EXT_CTRL, 16'h02C8);
    rdc(ADR, REG_QSTAT, 16'h9010);
    // Hardware reset takes the straps again
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(20);
    check(phy_addr, 5'h14);
    rdc(5'h14, REG_EXT_CTRL, 16'h0508);
    complete_run();
  end
endmodule
`default_nettype wire
